// [include/cpm_consts.vh]
// Offsets, bit positions, reset values and counts of the CAN mode block
`ifndef CPM_CONSTS_VH
`define CPM_CONSTS_VH
// Register byte offsets, one 32-bit word each
`define CPM_ADR_CTL0 6'h00
`define CPM_ADR_CTL1 6'h04
`define CPM_ADR_RFLG 6'h08
`define CPM_ADR_RIER 6'h0C
`define CPM_ADR_TFLG 6'h10
`define CPM_ADR_TIER 6'h14
`define CPM_ADR_TARQ 6'h18
`define CPM_ADR_TAAK 6'h1C
`define CPM_ADR_TBSEL 6'h20
`define CPM_ADR_BTR0 6'h24
`define CPM_ADR_BTR1 6'h28
`define CPM_ADR_IDAC 6'h2C
// control_reg_0 fields
`define CPM_B_INIT_REQUEST 0
`define CPM_B_SLEEP_REQUEST 1
`define CPM_B_WAKEUP_ENABLE 2
`define CPM_B_STOP_IN_WAIT 5
// control_reg_1 fields
`define CPM_B_INIT_ACKNOWLEDGE 0
`define CPM_B_SLEEP_ACKNOWLEDGE 1
`define CPM_B_WAKEUP_FILTER_MODE 2
// rx_flag_reg and rx_int_enable_reg fields
`define CPM_B_RXF 0
`define CPM_B_OVR 1
`define CPM_B_CSC 6
`define CPM_B_WUP 7
// Reset values
`define CPM_RST_TFLG 3'h7
`define CPM_RST_BYTE 8'h00
// Synchronizer stages towards the protocol side and back
`define CPM_SYNC_BUS 4'h2
`define CPM_SYNC_CAN 4'h3
// Recessive bits needed to resynchronize
`define CPM_REC_BITS 16'h000B
// Defaults for counts that a simulation may shorten
`define CPM_BIT_CYCLES 16'h01F4
`define CPM_RECOVER_CYCLES 16'h0040
`define CPM_FILTER_CYCLES 8'h32
`endif

// [src/cpm_rx_filter.v]
// Receive pin synchronizer and wake-up glitch filter
`timescale 1ns/1ps
`default_nettype none
`include "cpm_consts.vh"
module cpm_rx_filter #(
  parameter [7:0] FILTER_CYCLES = `CPM_FILTER_CYCLES
) (
  input wire clk_i,
  input wire rst_i,
  input wire pin_i,
  input wire filt_en_i,
  output reg level_o,
  output reg act_o
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  reg [7:0] cnt_r;

  // Three stages; a level counts once stages two and three agree
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      level_o <= 1'b1;
    end
    else
    begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        level_o <= s3_r;
    end
  end

  // Dominant run length; with the filter on, short pulses never wake
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r <= 8'h00;
      act_o <= 1'b0;
    end
    else
    begin
      if (level_o)
        cnt_r <= 8'h00;
      else if (cnt_r != 8'hFF)
        cnt_r <= cnt_r + 8'h01;
      act_o <= ~level_o & (~filt_en_i | (cnt_r >= FILTER_CYCLES));
    end
  end
endmodule // cpm_rx_filter
`default_nettype wire

// [src/cpm_ctrl.v]
// CAN controller mode control, power modes and interrupt flags
//
// Functional notes
// - Deep stop forces power-down regardless of sleep bits; stop_in_wait ignored.
// - Lightest stop picks sleep or power-down from bits held at entry.
// - Sleep waits until every transmit buffer is empty.
// - Sleep during reception waits for the bus to go idle.
// - Idle controller sleeps after a fixed synchronization delay only.
// - Acknowledge rises once sleep is active; software waits for it.
// - In sleep protocol clocks stop, register clocks keep running.
// - Bus-off recessive count freezes in sleep, transmit pin recessive.
// - No background to foreground receive move while sleeping.
// - Transmit flags stay clearable in sleep; no abort runs then.
// - Wake-up disabled holds internal receive recessive, locking sleep.
// - Sleep ends on enabled bus activity or cleared sleep request.
// - Clearing requests is ignored until the matching acknowledge is set.
// - After wake-up wait 11 recessive bits before taking part again.
// - Deferred receive moves, aborts and transmissions run after wake-up.
// - Initialization aborts traffic and drives transmit pin recessive at once.
// - Initialization resets control, flag, enable, abort and select registers.
// - Init request passes all domains before its acknowledge rises.
// - CPU stop, or wait with stop_in_wait, gives power-down, access blocked.
// - Power-down without prior sleep runs a fixed recovery delay.
// - Filter mode suppresses short receive glitches as wake-up causes.
// - Four maskable interrupts: wake-up, error, receive-full, transmit-empty.
// - Flags clear by writing one, never while their cause persists.
// - Wake-up flag only when asleep with wake-up enabled.
//
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cpm_consts.vh"
module cpm_ctrl #(
  parameter [15:0] BIT_CYCLES = `CPM_BIT_CYCLES,
  parameter [15:0] RECOVER_CYCLES = `CPM_RECOVER_CYCLES,
  parameter [7:0] FILTER_CYCLES = `CPM_FILTER_CYCLES
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire cpu_wait_i,
  input wire cpu_stop3_i,
  input wire cpu_stop_deep_i,
  input wire tx_active_i,
  input wire rx_active_i,
  input wire bus_idle_i,
  input wire bus_off_i,
  input wire rx_bg_valid_i,
  input wire status_change_i,
  input wire overrun_i,
  input wire [2:0] tx_done_i,
  input wire [2:0] tx_busy_i,
  input wire proto_tx_i,
  input wire can_receive_pin_i,
  output reg can_transmit_pin_o,
  output reg rx_internal_o,
  output reg proto_clk_en_o,
  output reg regs_clk_en_o,
  output reg bo_count_freeze_o,
  output reg rx_shift_o,
  output reg [2:0] tx_start_o,
  output reg [2:0] abort_o,
  output reg [23:0] bit_timing_o,
  output reg irq_wakeup_o,
  output reg irq_error_o,
  output reg irq_rx_o,
  output reg irq_tx_o
);
  localparam [3:0] ST_NORMAL = 4'h0;
  localparam [3:0] ST_SLP_WAIT = 4'h1;
  localparam [3:0] ST_SLP_SYNC = 4'h2;
  localparam [3:0] ST_SLEEP = 4'h3;
  localparam [3:0] ST_RESYNC = 4'h4;
  localparam [3:0] ST_INIT_SYNC = 4'h5;
  localparam [3:0] ST_INIT = 4'h6;
  localparam [3:0] ST_PDOWN = 4'h7;
  localparam [3:0] ST_RECOVER = 4'h8;
  localparam [15:0] REC_LEN = `CPM_REC_BITS * BIT_CYCLES;
  localparam [3:0] SYNC_LEN = `CPM_SYNC_BUS + `CPM_SYNC_CAN;
  localparam [2:0] TXE_RST = `CPM_RST_TFLG;

  reg [3:0] state_r;
  reg [15:0] cnt_r;
  reg init_request_r;
  reg sleep_request_r;
  reg wakeup_enable_r;
  reg stop_in_wait_r;
  reg init_acknowledge_r;
  reg sleep_acknowledge_r;
  reg wakeup_filter_mode_r;
  reg wakeup_int_flag_r;
  reg status_change_flag_r;
  reg overrun_flag_r;
  reg rxf_r;
  reg [7:0] rier_r;
  reg [2:0] tier_r;
  reg [2:0] tbsel_r;
  reg stop3_prev_r;
  reg stop3_slp_r;
  reg pd_slept_r;
  wire rx_level;
  wire rx_act;
  wire [2:0] txe;
  wire [2:0] arq;
  wire [2:0] aak;
  wire acc;
  wire wr;
  wire [7:0] wd;
  wire run;
  wire asleep;
  wire stop3_slp;
  wire pd_cond;
  wire wake_act;
  wire init_go;

  cpm_rx_filter #(
    .FILTER_CYCLES(FILTER_CYCLES)
  ) u_filt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(can_receive_pin_i),
    .filt_en_i(wakeup_filter_mode_r),
    .level_o(rx_level),
    .act_o(rx_act)
  );

  // Bus decode; register access is refused in power-down
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o & (state_r != ST_PDOWN);
  assign wr = acc & wb_we_i & wb_sel_i[0];
  assign wd = wb_dat_i[7:0];
  assign run = (state_r == ST_NORMAL) | (state_r == ST_SLP_WAIT) |
               (state_r == ST_SLP_SYNC);
  assign asleep = (state_r == ST_SLEEP) |
                  ((state_r == ST_PDOWN) & pd_slept_r);
  // Sleep bits are sampled as stop3 begins and held through it
  assign stop3_slp = stop3_prev_r ? stop3_slp_r : sleep_acknowledge_r;
  assign pd_cond = cpu_stop_deep_i | (cpu_stop3_i & ~stop3_slp) |
                   (cpu_wait_i & stop_in_wait_r & ~cpu_stop3_i);
  // Masked activity cannot wake, so sleep is locked without wakeup_enable
  assign wake_act = asleep & wakeup_enable_r & rx_act;
  assign init_go = init_request_r & (state_r != ST_INIT_SYNC) &
                   (state_r != ST_INIT) & (state_r != ST_PDOWN);

  // Stop3 entry latch
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stop3_prev_r <= 1'b0;
      stop3_slp_r <= 1'b0;
    end
    else
    begin
      stop3_prev_r <= cpu_stop3_i;
      if (cpu_stop3_i & ~stop3_prev_r)
        stop3_slp_r <= sleep_acknowledge_r;
    end
  end

  // Mode sequencer
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_INIT;
      cnt_r <= 16'h0000;
      sleep_acknowledge_r <= 1'b0;
      init_acknowledge_r <= 1'b1;
      pd_slept_r <= 1'b0;
    end
    else if (pd_cond & (state_r != ST_PDOWN))
    begin
      // Power-down overrides everything and halts traffic at once
      pd_slept_r <= (state_r == ST_SLEEP);
      state_r <= ST_PDOWN;
    end
    else if (init_go)
    begin
      state_r <= ST_INIT_SYNC;
      cnt_r <= 16'h0000;
    end
    else
    begin
      case (state_r)
        ST_NORMAL:
          if (sleep_request_r)
            state_r <= ST_SLP_WAIT;
        ST_SLP_WAIT:
          // Pending buffers and a frame in flight both hold off sleep
          if ((txe == 3'h7) & ~tx_active_i & (~rx_active_i | bus_idle_i))
          begin
            state_r <= ST_SLP_SYNC;
            cnt_r <= 16'h0000;
          end
        ST_SLP_SYNC:
          if (cnt_r[3:0] == SYNC_LEN)
          begin
            state_r <= ST_SLEEP;
            sleep_acknowledge_r <= 1'b1;
          end
          else
            cnt_r <= cnt_r + 16'h0001;
        ST_SLEEP:
          if (wake_act | ~sleep_request_r)
          begin
            state_r <= ST_RESYNC;
            sleep_acknowledge_r <= 1'b0;
            cnt_r <= 16'h0000;
          end
        ST_RESYNC:
          // A frame that woke us is lost while we wait for idle bits
          if (~rx_level)
            cnt_r <= 16'h0000;
          else if (cnt_r == REC_LEN)
            state_r <= ST_NORMAL;
          else
            cnt_r <= cnt_r + 16'h0001;
        ST_INIT_SYNC:
          if (cnt_r[3:0] == SYNC_LEN)
          begin
            state_r <= ST_INIT;
            init_acknowledge_r <= 1'b1;
            // Init clears the sleep request, so a stale sleep ack must go too
            sleep_acknowledge_r <= 1'b0;
          end
          else
            cnt_r <= cnt_r + 16'h0001;
        ST_INIT:
          if (~init_request_r)
          begin
            state_r <= ST_RESYNC;
            init_acknowledge_r <= 1'b0;
            cnt_r <= 16'h0000;
          end
        ST_PDOWN:
          if (~pd_cond)
          begin
            cnt_r <= 16'h0000;
            state_r <= pd_slept_r ? ST_SLEEP : ST_RECOVER;
          end
          else if (wake_act)
          begin
            state_r <= ST_PDOWN;
          end
        ST_RECOVER:
          if (cnt_r == RECOVER_CYCLES)
          begin
            state_r <= ST_RESYNC;
            sleep_acknowledge_r <= 1'b0;
            cnt_r <= 16'h0000;
          end
          else
            cnt_r <= cnt_r + 16'h0001;
        default:
          state_r <= ST_INIT;
      endcase
    end
  end

  // Control bits; requests cannot be withdrawn before acknowledge
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      init_request_r <= 1'b1;
      sleep_request_r <= 1'b0;
      wakeup_enable_r <= 1'b0;
      stop_in_wait_r <= 1'b0;
      wakeup_filter_mode_r <= 1'b0;
      tbsel_r <= 3'h0;
      rier_r <= `CPM_RST_BYTE;
      tier_r <= 3'h0;
      bit_timing_o <= 24'h000000;
    end
    else if ((state_r == ST_INIT_SYNC) & (cnt_r[3:0] == SYNC_LEN))
    begin
      sleep_request_r <= 1'b0;
      wakeup_enable_r <= 1'b0;
      stop_in_wait_r <= 1'b0;
      tbsel_r <= 3'h0;
      rier_r <= `CPM_RST_BYTE;
      tier_r <= 3'h0;
    end
    else if (wr)
    begin
      if (wb_adr_i == `CPM_ADR_CTL0)
      begin
        if (wd[`CPM_B_INIT_REQUEST] | init_acknowledge_r)
          init_request_r <= wd[`CPM_B_INIT_REQUEST];
        if (wd[`CPM_B_SLEEP_REQUEST] | sleep_acknowledge_r)
          sleep_request_r <= wd[`CPM_B_SLEEP_REQUEST];
        wakeup_enable_r <= wd[`CPM_B_WAKEUP_ENABLE];
        stop_in_wait_r <= wd[`CPM_B_STOP_IN_WAIT];
      end
      else if (wb_adr_i == `CPM_ADR_CTL1)
        wakeup_filter_mode_r <= wd[`CPM_B_WAKEUP_FILTER_MODE];
      else if (wb_adr_i == `CPM_ADR_RIER)
        rier_r <= wd;
      else if (wb_adr_i == `CPM_ADR_TIER)
        tier_r <= wd[2:0];
      else if (wb_adr_i == `CPM_ADR_TBSEL)
        tbsel_r <= wd[2:0];
      else if (init_acknowledge_r & (wb_adr_i == `CPM_ADR_BTR0))
        bit_timing_o[7:0] <= wd;
      else if (init_acknowledge_r & (wb_adr_i == `CPM_ADR_BTR1))
        bit_timing_o[15:8] <= wd;
      else if (init_acknowledge_r & (wb_adr_i == `CPM_ADR_IDAC))
        bit_timing_o[23:16] <= wd;
    end
  end

  // Receive side flags; a set in the clearing cycle wins
  always @(posedge clk_i)
  begin
    if (rst_i | ((state_r == ST_INIT_SYNC) & (cnt_r[3:0] == SYNC_LEN)))
    begin
      wakeup_int_flag_r <= 1'b0;
      status_change_flag_r <= 1'b0;
      overrun_flag_r <= 1'b0;
      rxf_r <= 1'b0;
    end
    else
    begin
      if (wake_act)
        wakeup_int_flag_r <= 1'b1;
      else if (wr & (wb_adr_i == `CPM_ADR_RFLG) & wd[`CPM_B_WUP])
        wakeup_int_flag_r <= 1'b0;
      if (status_change_i)
        status_change_flag_r <= 1'b1;
      else if (wr & (wb_adr_i == `CPM_ADR_RFLG) & wd[`CPM_B_CSC])
        status_change_flag_r <= 1'b0;
      if (overrun_i)
        overrun_flag_r <= 1'b1;
      else if (wr & (wb_adr_i == `CPM_ADR_RFLG) & wd[`CPM_B_OVR])
        overrun_flag_r <= 1'b0;
      if (rx_shift_o)
        rxf_r <= 1'b1;
      else if (wr & (wb_adr_i == `CPM_ADR_RFLG) & wd[`CPM_B_RXF])
        rxf_r <= 1'b0;
    end
  end

  // Per-buffer empty flag, abort request and abort acknowledge
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_buf
      reg txe_r;
      reg arq_r;
      reg aak_r;
      wire abort_now;
      // Aborts only run with protocol clocks, so none happen in sleep
      assign abort_now = run & arq_r & ~txe_r & ~tx_busy_i[gi];
      always @(posedge clk_i)
      begin
        if (rst_i | ((state_r == ST_INIT_SYNC) & (cnt_r[3:0] == SYNC_LEN)))
        begin
          txe_r <= TXE_RST[gi];
          arq_r <= 1'b0;
          aak_r <= 1'b0;
        end
        else
        begin
          if (tx_done_i[gi] | abort_now)
            txe_r <= 1'b1;
          else if (wr & (wb_adr_i == `CPM_ADR_TFLG) & wd[gi])
            txe_r <= 1'b0;
          if (abort_now | txe_r)
            arq_r <= 1'b0;
          else if (wr & (wb_adr_i == `CPM_ADR_TARQ) & wd[gi])
            arq_r <= 1'b1;
          if (abort_now)
            aak_r <= 1'b1;
          else if (wr & (wb_adr_i == `CPM_ADR_TFLG) & wd[gi])
            aak_r <= 1'b0;
        end
      end
      assign txe[gi] = txe_r;
      assign arq[gi] = arq_r;
      assign aak[gi] = aak_r;
    end
  endgenerate

  // Bus answer: one cycle after the request, zero for unmapped offsets
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= 32'h00000000;
      if (acc & ~wb_we_i)
      begin
        if (wb_adr_i == `CPM_ADR_CTL0)
          wb_dat_o[7:0] <= {2'h0, stop_in_wait_r, 2'h0, wakeup_enable_r, sleep_request_r, init_request_r};
        else if (wb_adr_i == `CPM_ADR_CTL1)
          wb_dat_o[7:0] <= {5'h00, wakeup_filter_mode_r, sleep_acknowledge_r, init_acknowledge_r};
        else if (wb_adr_i == `CPM_ADR_RFLG)
          wb_dat_o[7:0] <= {wakeup_int_flag_r, status_change_flag_r, 4'h0, overrun_flag_r, rxf_r};
        else if (wb_adr_i == `CPM_ADR_RIER)
          wb_dat_o[7:0] <= rier_r;
        else if (wb_adr_i == `CPM_ADR_TFLG)
          wb_dat_o[2:0] <= txe;
        else if (wb_adr_i == `CPM_ADR_TIER)
          wb_dat_o[2:0] <= tier_r;
        else if (wb_adr_i == `CPM_ADR_TARQ)
          wb_dat_o[2:0] <= arq;
        else if (wb_adr_i == `CPM_ADR_TAAK)
          wb_dat_o[2:0] <= aak;
        else if (wb_adr_i == `CPM_ADR_TBSEL)
          wb_dat_o[2:0] <= tbsel_r;
        else if (wb_adr_i == `CPM_ADR_BTR0)
          wb_dat_o[7:0] <= bit_timing_o[7:0];
        else if (wb_adr_i == `CPM_ADR_BTR1)
          wb_dat_o[7:0] <= bit_timing_o[15:8];
        else if (wb_adr_i == `CPM_ADR_IDAC)
          wb_dat_o[7:0] <= bit_timing_o[23:16];
      end
    end
  end

  // Pin, clock gating and protocol handoff outputs
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      can_transmit_pin_o <= 1'b1;
      rx_internal_o <= 1'b1;
      proto_clk_en_o <= 1'b0;
      regs_clk_en_o <= 1'b1;
      bo_count_freeze_o <= 1'b0;
      rx_shift_o <= 1'b0;
      tx_start_o <= 3'h0;
      abort_o <= 3'h0;
    end
    else
    begin
      // Recessive whenever not running, so aborted frames stay harmless
      can_transmit_pin_o <= (run & ~pd_cond & ~init_go) ? proto_tx_i :
                            1'b1;
      rx_internal_o <= (asleep & ~wakeup_enable_r) ? 1'b1 : rx_level;
      proto_clk_en_o <= run | (state_r == ST_RESYNC);
      regs_clk_en_o <= (state_r != ST_PDOWN);
      bo_count_freeze_o <= bus_off_i & (asleep |
                           (state_r == ST_PDOWN));
      rx_shift_o <= run & rx_bg_valid_i & ~rxf_r & ~rx_shift_o;
      tx_start_o <= run ? (~txe & ~arq) : 3'h0;
      abort_o <= run ? (arq & ~aak) : 3'h0;
    end
  end

  // Interrupt requests, each gated by its local enables
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_wakeup_o <= 1'b0;
      irq_error_o <= 1'b0;
      irq_rx_o <= 1'b0;
      irq_tx_o <= 1'b0;
    end
    else
    begin
      irq_wakeup_o <= wakeup_int_flag_r & rier_r[`CPM_B_WUP];
      irq_error_o <= (status_change_flag_r & rier_r[`CPM_B_CSC]) |
                     (overrun_flag_r & rier_r[`CPM_B_OVR]);
      irq_rx_o <= rxf_r & rier_r[`CPM_B_RXF];
      irq_tx_o <= |(txe & tier_r);
    end
  end
endmodule // cpm_ctrl
`default_nettype wire

// [test/cpm_can_node.sv]
// Far-side CAN node: recessive idle, dominant bursts on command
`timescale 1ns/1ps
`default_nettype none
module cpm_can_node (
  input wire logic clk_i,
  input wire logic dut_tx_i,
  input wire logic [7:0] burst_i,
  input wire logic go_i,
  output logic rx_o
);
  logic [7:0] left_r = 8'h00;
  // Count down the dominant burst, one bus cycle per clock
  always @(posedge clk_i)
  begin
    if (go_i)
      left_r <= burst_i;
    else if (left_r != 8'h00)
      left_r <= left_r - 8'h01;
  end
  // Wired-AND bus: either node pulls it dominant, the transceiver idles high
  assign rx_o = dut_tx_i & (left_r == 8'h00);
endmodule // cpm_can_node
`default_nettype wire

// [test/cpm_ctrl_asserts.sv]
// Port-level checks of the CAN mode block, bound into the design
`timescale 1ns/1ps
`default_nettype none
module cpm_ctrl_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic cpu_stop_deep_i,
  input wire logic bus_off_i,
  input wire logic can_transmit_pin_o,
  input wire logic proto_clk_en_o,
  input wire logic regs_clk_en_o,
  input wire logic bo_count_freeze_o,
  input wire logic rx_shift_o,
  input wire logic [2:0] tx_start_o,
  input wire logic [2:0] abort_o,
  input wire logic irq_wakeup_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // A stopped protocol side must leave the bus recessive
  pin_stop_a: assert property (
    !proto_clk_en_o |-> can_transmit_pin_o)
    else $error("pin dominant while stopped");
  pdown_deep_a: assert property (
    $rose(cpu_stop_deep_i) |-> ##[1:4] !regs_clk_en_o)
    else $error("deep stop kept clocks");
  pdown_read_a: assert property (
    wb_ack_o && !wb_we_i && !regs_clk_en_o && !$past(regs_clk_en_o)
    |-> wb_dat_o == 32'h0)
    else $error("register read in power-down");
  pdown_pin_a: assert property (
    !regs_clk_en_o |-> !proto_clk_en_o && can_transmit_pin_o)
    else $error("power-down with traffic");
  // Freeze only after bus-off; deferred work never runs while the protocol clocks stand
  freeze_a: assert property (
    bo_count_freeze_o |-> $past(bus_off_i) && can_transmit_pin_o)
    else $error("freeze without bus-off");
  abort_run_a: assert property (
    abort_o != 3'h0 |-> proto_clk_en_o)
    else $error("abort while stopped");
  start_run_a: assert property (
    tx_start_o != 3'h0 |-> proto_clk_en_o)
    else $error("transmit start while stopped");
  shift_run_a: assert property (
    rx_shift_o |-> proto_clk_en_o)
    else $error("receive move while stopped");
  // Two cycles before a wake request the block must have been asleep
  wake_irq_a: assert property (
    $rose(irq_wakeup_o) |-> !$past(proto_clk_en_o, 2))
    else $error("wake request while awake");
endmodule // cpm_ctrl_asserts
bind cpm_ctrl cpm_ctrl_asserts u_chk (
  .clk_i, .rst_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .cpu_stop_deep_i,
  .bus_off_i, .can_transmit_pin_o, .proto_clk_en_o, .regs_clk_en_o,
  .bo_count_freeze_o, .rx_shift_o, .tx_start_o, .abort_o, .irq_wakeup_o
);
`default_nettype wire

// [test/tb.sv]
// Bench for the CAN mode block: bus tasks and mode scenarios
`timescale 1ns/1ps
`default_nettype none
`include "cpm_consts.vh"
module tb;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0, ack;
  logic [5:0] adr = 6'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic cpu_wait = 1'h0, stop3 = 1'h0, deep = 1'h0, go = 1'h0;
  logic tx_act = 1'h0, rx_act = 1'h0, idle = 1'h1, boff = 1'h0;
  logic bgv = 1'h0, scf = 1'h0, ovr = 1'h0;
  logic [2:0] txd = 3'h0, tst;
  logic [7:0] blen = 8'h00;
  logic rxpin, txpin, pclk, rclk, frz, iw, ie, ir, it, rxi;
  logic [23:0] btim;
  int failures = 0, total_checks = 0, n, k, t0, cnt = 0;
  // 250 MHz clock and a free cycle count for timing checks
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) cnt <= cnt + 1;
  // Short counts keep the resync and recovery waits small
  cpm_ctrl #(.BIT_CYCLES(16'h0004), .RECOVER_CYCLES(16'h0008),
    .FILTER_CYCLES(8'h03)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .cpu_wait_i(cpu_wait),
    .cpu_stop3_i(stop3), .cpu_stop_deep_i(deep), .tx_active_i(tx_act),
    .rx_active_i(rx_act), .bus_idle_i(idle), .bus_off_i(boff),
    .rx_bg_valid_i(bgv), .status_change_i(scf), .overrun_i(ovr),
    .tx_done_i(txd), .tx_busy_i(3'h0), .proto_tx_i(1'h1),
    .can_receive_pin_i(rxpin), .can_transmit_pin_o(txpin),
    .rx_internal_o(rxi), .proto_clk_en_o(pclk), .regs_clk_en_o(rclk),
    .bo_count_freeze_o(frz), .rx_shift_o(), .tx_start_o(tst),
    .abort_o(), .bit_timing_o(btim), .irq_wakeup_o(iw),
    .irq_error_o(ie), .irq_rx_o(ir), .irq_tx_o(it));
  cpm_can_node u_node (.clk_i(clk_i), .dut_tx_i(txpin), .burst_i(blen),
    .go_i(go), .rx_o(rxpin));
  // Verdict and the single end of the run
  task automatic test_done;
  begin
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
  begin
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  end
  endtask
  // A wait that ran out ends the run as a mismatch
  task automatic lim(input int m);
  begin
    if (m >= 300)
    begin
      failures++;
      $display("wrong value wait exp %0d got %0d", 299, m);
      test_done();
    end
  end
  endtask
  // Classic cycle: hold everything until ack is sampled high
  task automatic bus(input logic w, input logic [5:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int m;
  begin
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    for (m = 0; m < 300 && ack !== 1'h1; m++)
      @(posedge clk_i);
    lim(m);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
  begin
    bus(1'h1, a, d, q);
  end
  endtask
  task automatic rdm(input logic [5:0] a, input logic [31:0] m, e);
    logic [31:0] q;
  begin
    bus(1'h0, a, 32'h0, q);
    chk($sformatf("reg %h", a), e, q & m);
  end
  endtask
  // Reads until the masked field matches, bounded
  task automatic poll(input logic [5:0] a, input logic [31:0] m, e);
    int j;
    logic [31:0] q;
  begin
    for (j = 0; j < 300; j++)
    begin
      bus(1'h0, a, 32'h0, q);
      if ((q & m) === e)
        break;
    end
    lim(j);
    chk($sformatf("poll %h", a), e, q & m);
  end
  endtask
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    // Out of reset in init: timing writable, clears refused early
    rdm(`CPM_ADR_CTL1, 32'hFF, 32'h01);
    rdm(`CPM_ADR_TFLG, 32'hFF, 32'h07);
    rdm(6'h3C, 32'hFFFFFFFF, 32'h0);
    wr(`CPM_ADR_BTR0, 32'h5A);
    wr(`CPM_ADR_CTL0, 32'h00);
    poll(`CPM_ADR_CTL1, 32'h01, 32'h00);
    wr(`CPM_ADR_BTR0, 32'hA5);
    rdm(`CPM_ADR_BTR0, 32'hFF, 32'h5A);
    chk("bit timing", 32'h5A, {8'h00, btim});
    wr(`CPM_ADR_TIER, 32'h07);
    wr(`CPM_ADR_CTL0, 32'h01);
    wr(`CPM_ADR_CTL0, 32'h00);
    rdm(`CPM_ADR_CTL0, 32'hFF, 32'h01);
    poll(`CPM_ADR_CTL1, 32'h01, 32'h01);
    rdm(`CPM_ADR_TIER, 32'hFF, 32'h00);
    wr(`CPM_ADR_CTL0, 32'h00);
    poll(`CPM_ADR_CTL1, 32'h01, 32'h00);
    $display("init test done");
    // Sleep waits for the last transmit, then for an idle bus
    wr(`CPM_ADR_RIER, 32'h81);
    wr(`CPM_ADR_CTL1, 32'h04);
    wr(`CPM_ADR_TFLG, 32'h01);
    // Resync must be over, or the hold-off checks below prove nothing
    for (n = 0; n < 300 && tst[0] !== 1'h1; n++)
      @(posedge clk_i);
    lim(n);
    tx_act <= 1'h1;
    rx_act <= 1'h1;
    idle <= 1'h0;
    wr(`CPM_ADR_CTL0, 32'h06);
    wr(`CPM_ADR_CTL0, 32'h04);
    rdm(`CPM_ADR_CTL0, 32'hFF, 32'h06);
    rdm(`CPM_ADR_CTL1, 32'h02, 32'h00);
    txd <= 3'h1;
    tx_act <= 1'h0;
    @(posedge clk_i);
    txd <= 3'h0;
    repeat (12) @(posedge clk_i);
    rdm(`CPM_ADR_CTL1, 32'h02, 32'h00);
    idle <= 1'h1;
    poll(`CPM_ADR_CTL1, 32'h02, 32'h02);
    chk("clocks", 32'h1, {30'h0, pclk, rclk});
    // Asleep: flags writable, receive move and starts held back
    bgv <= 1'h1;
    boff <= 1'h1;
    wr(`CPM_ADR_TFLG, 32'h04);
    wr(`CPM_ADR_TARQ, 32'h02);
    rdm(`CPM_ADR_TFLG, 32'hFF, 32'h03);
    rdm(`CPM_ADR_RFLG, 32'hC3, 32'h00);
    chk("freeze", 32'h1, {31'h0, frz});
    $display("sleep test done");
    // A short glitch is filtered, a long dominant phase wakes
    go <= 1'h1;
    blen <= 8'h02;
    @(posedge clk_i);
    go <= 1'h0;
    repeat (12) @(posedge clk_i);
    chk("wake irq", 32'h0, {31'h0, iw});
    // Without wake-up enable a long dominant phase is masked
    wr(`CPM_ADR_CTL0, 32'h02);
    go <= 1'h1;
    blen <= 8'h14;
    @(posedge clk_i);
    go <= 1'h0;
    repeat (10) @(posedge clk_i);
    chk("masked rx", 32'h1, {31'h0, rxi});
    repeat (20) @(posedge clk_i);
    chk("locked irq", 32'h0, {31'h0, iw});
    rdm(`CPM_ADR_CTL1, 32'h02, 32'h02);
    wr(`CPM_ADR_CTL0, 32'h06);
    t0 = cnt;
    go <= 1'h1;
    blen <= 8'h14;
    boff <= 1'h0;
    @(posedge clk_i);
    go <= 1'h0;
    for (n = 0; n < 300 && iw !== 1'h1; n++)
      @(posedge clk_i);
    lim(n);
    rdm(`CPM_ADR_RFLG, 32'h80, 32'h80);
    wr(`CPM_ADR_CTL0, 32'h04);
    for (n = 0; n < 300 && tst[2] !== 1'h1; n++)
      @(posedge clk_i);
    lim(n);
    chk("resync", 32'h1, {31'h0, cnt - t0 >= 64});
    poll(`CPM_ADR_RFLG, 32'h01, 32'h01);
    bgv <= 1'h0;
    chk("irq rx tx", 32'h2, {30'h0, ir, it});
    wr(`CPM_ADR_RFLG, 32'h81);
    rdm(`CPM_ADR_RFLG, 32'h81, 32'h00);
    chk("wake irq", 32'h0, {31'h0, iw});
    $display("wake test done");
    // A flag holds while its cause holds; enables gate requests
    scf <= 1'h1;
    wr(`CPM_ADR_RIER, 32'h42);
    wr(`CPM_ADR_RFLG, 32'h40);
    rdm(`CPM_ADR_RFLG, 32'h40, 32'h40);
    chk("error irq", 32'h1, {31'h0, ie});
    scf <= 1'h0;
    ovr <= 1'h1;
    wr(`CPM_ADR_RFLG, 32'h40);
    rdm(`CPM_ADR_RFLG, 32'h42, 32'h02);
    ovr <= 1'h0;
    wr(`CPM_ADR_TIER, 32'h03);
    wr(`CPM_ADR_RFLG, 32'h02);
    rdm(`CPM_ADR_RFLG, 32'hC3, 32'h00);
    chk("irq err tx", 32'h1, {30'h0, ie, it});
    $display("flag test done");
    // Wait with stop_in_wait, stop3 while awake, deep stop
    wr(`CPM_ADR_CTL0, 32'h24);
    for (k = 0; k < 3; k++)
    begin
      {deep, stop3, cpu_wait} <= 3'h1 << k;
      repeat (6) @(posedge clk_i);
      chk("regs clock", 32'h0, {31'h0, rclk});
      rdm(`CPM_ADR_TIER, 32'hFF, 32'h00);
      {deep, stop3, cpu_wait} <= 3'h0;
      for (n = 0; n < 300 && pclk !== 1'h1; n++)
        @(posedge clk_i);
      lim(n);
      chk("recovery", 32'h1, {31'h0, n >= 8});
    end
    $display("power test done");
    test_done();
  end
endmodule // tb
`default_nettype wire
